// ### rtl/crf_pkg.sv
package crf_pkg;

    // ==========================================================
    // Register file geometry
    // ==========================================================
    localparam int GPR_COUNT = 8;
    localparam int GPR_WIDTH = 32;
    localparam logic [2:0] SP_INDEX = 3'h7;
    localparam logic [31:0] PC_RESET = 32'h00000000;

    // ==========================================================
    // Condition flags layout and reset
    // ==========================================================
    localparam int CCR_I = 7;
    localparam int CCR_UI = 6;
    localparam int CCR_H = 5;
    localparam int CCR_U = 4;
    localparam int CCR_N = 3;
    localparam int CCR_Z = 2;
    localparam int CCR_V = 1;
    localparam int CCR_C = 0;
    // Only the mask bit is defined at reset; the rest are cleared here
    localparam logic [7:0] CCR_RESET = 8'h80;

    // ==========================================================
    // Other control registers
    // ==========================================================
    localparam logic [7:0] EXR_RESET = 8'h87;
    localparam logic [7:0] EXR_FIXED_ONES = 8'h78;
    localparam logic [31:0] VBR_RESET = 32'h00000000;
    localparam logic [31:0] VBR_KEEP = 32'hFFFFF000;
    localparam logic [31:0] SBR_RESET = 32'hFFFFFF00;
    localparam logic [31:0] SBR_KEEP = 32'hFFFFFF00;
    localparam logic [63:0] MAC_RESET = 64'h0000000000000000;

    // ==========================================================
    // Flag arithmetic: operands are left aligned to bit 31
    // ==========================================================
    localparam int BYTE_SHIFT = 24;
    localparam int WORD_SHIFT = 16;
    localparam int HALF_BOUNDARY = 28;

    // ==========================================================
    // Types
    // ==========================================================
    typedef enum logic [2:0] {
        CRF_VIEW_LONG = 3'b000, CRF_VIEW_EXT = 3'b001, CRF_VIEW_WORD = 3'b010,
        CRF_VIEW_BYTEH = 3'b011, CRF_VIEW_BYTEL = 3'b100
    } crf_view_t;
    typedef enum logic [1:0] {
        CRF_SZ_BYTE = 2'b00, CRF_SZ_WORD = 2'b01, CRF_SZ_LONG = 2'b10
    } crf_size_t;
    typedef enum logic [3:0] {
        CRF_ALU_ADD = 4'b0000, CRF_ALU_ADDX = 4'b0001, CRF_ALU_SUB = 4'b0010,
        CRF_ALU_SUBX = 4'b0011, CRF_ALU_CMP = 4'b0100, CRF_ALU_NEG = 4'b0101,
        CRF_ALU_MOVE = 4'b0110, CRF_ALU_SHIFT = 4'b0111, CRF_ALU_BITACC = 4'b1000
    } crf_alu_op_t;
    typedef enum logic [1:0] {
        CRF_CTL_LOAD = 2'b00, CRF_CTL_AND = 2'b01, CRF_CTL_OR = 2'b10, CRF_CTL_XOR = 2'b11
    } crf_ctl_op_t;
    typedef enum logic [2:0] {
        CRF_SEL_CCR = 3'b000, CRF_SEL_EXR = 3'b001, CRF_SEL_VBR = 3'b010,
        CRF_SEL_SBR = 3'b011, CRF_SEL_MACH = 3'b100, CRF_SEL_MACL = 3'b101
    } crf_ctl_sel_t;

    typedef struct packed {
        logic en;
        logic [2:0] idx;
        crf_view_t view;
        logic [31:0] data;
    } crf_gpr_wr_t;

    typedef struct packed {
        logic en;
        crf_alu_op_t op;
        crf_size_t size;
        logic [31:0] a;
        logic [31:0] b;
        logic bitIn;
    } crf_alu_req_t;

    typedef struct packed {
        logic en;
        crf_ctl_op_t op;
        crf_ctl_sel_t sel;
        logic [31:0] data;
    } crf_ctl_req_t;

    // Whole programmer-visible state of the register file, registered as one word
    typedef struct packed {
        logic [GPR_COUNT-1:0][GPR_WIDTH-1:0] gpr; // General registers
        logic [31:0] pc; // Program counter
        logic [7:0] condition_flags; // Condition flags
        logic [7:0] extended_control; // Extended control
        logic [31:0] vector_base; // Vector base
        logic [31:0] short_address_base; // Short address base
        logic [63:0] mac; // Multiply-accumulate
    } crf_state_t;

    // Flags and sized result of the datapath request in flight
    typedef struct packed {
        logic h; // Half carry
        logic n; // Negative
        logic z; // Zero
        logic v; // Overflow
        logic c; // Carry or borrow
        logic [31:0] res; // Result, zero-extended
    } crf_flags_t;

endpackage

// ### rtl/crf_register_file.sv
// Functional notes
// - Eight interchangeable 32-bit general registers
// - Data access as 32, 16, 8 bits
// - Each register splits into two 16-bit halves
// - Lower half splits into high, low byte
// - Index views chosen by operand size field
// - Register seven doubles as stack pointer
// - 32-bit program counter holds next address
// - Fetch address always has bit zero clear
// - Flags register: load, store, AND, OR, XOR
// - Bit 7 masks interrupts, resets to 1
// - Exception start forces interrupt mask set
// - Bits 6, 4 user bits; 6 masks too
// - Byte arithmetic half-carry at bit 3
// - Word arithmetic half-carry at bit 11
// - Long arithmetic half-carry at bit 27
// - Negative flag copies result sign bit
// - Branch conditions use N, Z, V, C
// - Control registers of documented widths exist
// - Zero flag set on zero result
// - Overflow flag set on arithmetic overflow
// - Carry from add, subtract, shift; bit accumulator
module crf_register_file #(
    parameter logic [31:0] RESET_PC = crf_pkg::PC_RESET
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [2:0] rdAIdx,
    input wire crf_pkg::crf_view_t rdAView,
    output logic [31:0] rdAData,
    input wire logic [2:0] rdBIdx,
    input wire crf_pkg::crf_view_t rdBView,
    output logic [31:0] rdBData,
    input wire logic [2:0] idxSel,
    input wire crf_pkg::crf_size_t idxSize,
    output logic [31:0] idxData,
    input wire crf_pkg::crf_gpr_wr_t gprWr,
    input wire logic spLoad,
    input wire logic [31:0] spValue,
    output logic [31:0] stackPointer,
    input wire logic pcLoad,
    input wire logic [31:0] pcValue,
    input wire logic pcAdvance,
    input wire logic [3:0] pcStep,
    output logic [31:0] programCounter,
    output logic [31:0] fetchAddr,
    input wire crf_pkg::crf_alu_req_t aluReq,
    output logic [31:0] aluResult,
    input wire crf_pkg::crf_ctl_req_t ctlReq,
    input wire crf_pkg::crf_ctl_sel_t ctlRdSel,
    output logic [31:0] ctlRdData,
    input wire logic excStart,
    output logic [7:0] conditionFlags,
    output logic irqMasked,
    output logic userMask,
    output logic [3:0] branchFlags
);
    import crf_pkg::*;

    // ==========================================================
    // State
    // ==========================================================
    crf_state_t state_q; // Registered state
    crf_state_t state_d; // Next state
    crf_flags_t aluOut; // Flags and result of the current request

    // ==========================================================
    // Helper functions
    // ==========================================================
    // Extract one view of a register, zero-extended
    function automatic logic [31:0] readView(input logic [31:0] r, input crf_view_t v);
        logic [31:0] o;
        unique case (v)
            CRF_VIEW_LONG: o = r;
            CRF_VIEW_EXT: o = {16'h0000, r[31:16]};
            CRF_VIEW_WORD: o = {16'h0000, r[15:0]};
            CRF_VIEW_BYTEH: o = {24'h000000, r[15:8]};
            CRF_VIEW_BYTEL: o = {24'h000000, r[7:0]};
            default: o = 32'h00000000;
        endcase
        return o;
    endfunction
    // Merge new data into one view, other bits untouched
    function automatic logic [31:0] writeView(input logic [31:0] r, input crf_view_t v,
                                              input logic [31:0] d);
        logic [31:0] o;
        o = r;
        unique case (v)
            CRF_VIEW_LONG: o = d;
            CRF_VIEW_EXT: o[31:16] = d[15:0];
            CRF_VIEW_WORD: o[15:0] = d[15:0];
            CRF_VIEW_BYTEH: o[15:8] = d[7:0];
            CRF_VIEW_BYTEL: o[7:0] = d[7:0];
            default: o = r;
        endcase
        return o;
    endfunction
    // Left-align an operand so every size has its sign at bit 31
    function automatic logic [31:0] alignOp(input logic [31:0] x, input crf_size_t s);
        logic [31:0] o;
        unique case (s)
            CRF_SZ_BYTE: o = x << BYTE_SHIFT;
            CRF_SZ_WORD: o = x << WORD_SHIFT;
            CRF_SZ_LONG: o = x;
            default: o = x;
        endcase
        return o;
    endfunction

    // ==========================================================
    // Flag arithmetic
    // ==========================================================
    // Aligning the operands puts the bit 3, 11 and 27 carries all at one boundary
    always_comb begin
        logic [31:0] opA;
        logic [31:0] opB;
        logic [31:0] inj;
        logic [32:0] sum;
        logic isSub;
        logic useX;
        inj = 32'h00000000;
        sum = 33'h0;
        opA = alignOp(aluReq.a, aluReq.size);
        opB = alignOp(aluReq.b, aluReq.size);
        isSub = 1'b0;
        useX = (aluReq.op == CRF_ALU_ADDX) || (aluReq.op == CRF_ALU_SUBX);
        unique case (aluReq.op)
            CRF_ALU_SUB, CRF_ALU_SUBX, CRF_ALU_CMP: isSub = 1'b1;
            CRF_ALU_NEG: begin
                // Negate is a subtract from zero
                isSub = 1'b1;
                opB = opA;
                opA = 32'h00000000;
            end
            default: isSub = 1'b0;
        endcase
        // Extend carry enters at the operand's own lowest bit
        inj = alignOp({31'h00000000, useX & state_q.condition_flags[CCR_C]}, aluReq.size);
        if (isSub) begin
            sum = {1'b0, opA} - {1'b0, opB} - {1'b0, inj};
        end else begin
            sum = {1'b0, opA} + {1'b0, opB} + {1'b0, inj};
        end
        aluOut.h = sum[HALF_BOUNDARY] ^ opA[HALF_BOUNDARY] ^ opB[HALF_BOUNDARY];
        aluOut.c = sum[32];
        if (isSub) begin
            aluOut.v = (opA[31] != opB[31]) && (sum[31] != opA[31]);
        end else begin
            aluOut.v = (opA[31] == opB[31]) && (sum[31] != opA[31]);
        end
        aluOut.n = sum[31];
        aluOut.z = (sum[31:0] == 32'h00000000);
        unique case (aluReq.size)
            CRF_SZ_BYTE: aluOut.res = sum[31:0] >> BYTE_SHIFT;
            CRF_SZ_WORD: aluOut.res = sum[31:0] >> WORD_SHIFT;
            default: aluOut.res = sum[31:0];
        endcase
    end

    // ==========================================================
    // Next-state logic
    // ==========================================================
    always_comb begin
        logic [31:0] cur;
        logic [31:0] nv;
        logic [7:0] f;
        state_d = state_q;
        cur = 32'h00000000;
        nv = 32'h00000000;
        f = state_q.condition_flags;
        if (gprWr.en) begin
            state_d.gpr[gprWr.idx] = writeView(state_q.gpr[gprWr.idx], gprWr.view, gprWr.data);
        end
        // stack pointer update wins over the general write
        if (spLoad) begin
            state_d.gpr[SP_INDEX] = spValue;
        end
        if (pcLoad) begin
            state_d.pc = pcValue;
        end else if (pcAdvance) begin
            state_d.pc = state_q.pc + {28'h0000000, pcStep};
        end
        if (aluReq.en) begin
            unique case (aluReq.op)
                CRF_ALU_MOVE, CRF_ALU_SHIFT: begin
                    // Logical results: N, Z follow data, V cleared
                    f[CCR_N] = alignOp(aluReq.a, aluReq.size) >> 31 != 32'h0;
                    f[CCR_Z] = alignOp(aluReq.a, aluReq.size) == 32'h00000000;
                    f[CCR_V] = 1'b0;
                    if (aluReq.op == CRF_ALU_SHIFT) begin
                        f[CCR_C] = aluReq.bitIn;
                    end
                end
                CRF_ALU_BITACC: f[CCR_C] = aluReq.bitIn;
                default: begin
                    f[CCR_H] = aluOut.h;
                    f[CCR_N] = aluOut.n;
                    f[CCR_Z] = aluOut.z;
                    f[CCR_V] = aluOut.v;
                    f[CCR_C] = aluOut.c;
                end
            endcase
        end
        // Control-register instructions on the flags act on the result of any same-cycle datapath flag update
        if (ctlReq.en) begin
            unique case (ctlReq.sel)
                CRF_SEL_CCR: cur = {24'h000000, f};
                CRF_SEL_EXR: cur = {24'h000000, state_q.extended_control};
                CRF_SEL_VBR: cur = state_q.vector_base;
                CRF_SEL_SBR: cur = state_q.short_address_base;
                CRF_SEL_MACH: cur = state_q.mac[63:32];
                CRF_SEL_MACL: cur = state_q.mac[31:0];
                default: cur = 32'h00000000;
            endcase
            unique case (ctlReq.op)
                CRF_CTL_LOAD: nv = ctlReq.data;
                CRF_CTL_AND: nv = cur & ctlReq.data;
                CRF_CTL_OR: nv = cur | ctlReq.data;
                CRF_CTL_XOR: nv = cur ^ ctlReq.data;
            endcase
            // each target keeps only its valid bits
            unique case (ctlReq.sel)
                CRF_SEL_CCR: f = nv[7:0];
                CRF_SEL_EXR: state_d.extended_control = nv[7:0] | EXR_FIXED_ONES;
                CRF_SEL_VBR: state_d.vector_base = nv & VBR_KEEP;
                CRF_SEL_SBR: state_d.short_address_base = nv & SBR_KEEP;
                CRF_SEL_MACH: state_d.mac[63:32] = nv;
                CRF_SEL_MACL: state_d.mac[31:0] = nv;
                default: state_d.mac = state_q.mac;
            endcase
        end
        // exception entry sets the mask last, so nothing can undo it
        if (excStart) begin
            f[CCR_I] = 1'b1;
        end
        state_d.condition_flags = f;
    end

    // ==========================================================
    // State register
    // ==========================================================
    // mask bit comes up set
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state_q.gpr <= '0;
            state_q.pc <= RESET_PC;
            state_q.condition_flags <= CCR_RESET;
            state_q.extended_control <= EXR_RESET;
            state_q.vector_base <= VBR_RESET;
            state_q.short_address_base <= SBR_RESET;
            state_q.mac <= MAC_RESET;
        end else begin
            state_q <= state_d;
        end
    end

    // ==========================================================
    // Outputs
    // ==========================================================
    // any register, any view, on both ports
    assign rdAData = readView(state_q.gpr[rdAIdx], rdAView);
    assign rdBData = readView(state_q.gpr[rdBIdx], rdBView);
    always_comb begin
        idxData = 32'h00000000;
        unique case (idxSize)
            CRF_SZ_BYTE: idxData = readView(state_q.gpr[idxSel], CRF_VIEW_BYTEL);
            CRF_SZ_WORD: idxData = readView(state_q.gpr[idxSel], CRF_VIEW_WORD);
            CRF_SZ_LONG: idxData = state_q.gpr[idxSel];
            default: idxData = 32'h00000000;
        endcase
    end
    // Store-control reads see the registered value
    always_comb begin
        ctlRdData = 32'h00000000;
        unique case (ctlRdSel)
            CRF_SEL_CCR: ctlRdData = {24'h000000, state_q.condition_flags};
            CRF_SEL_EXR: ctlRdData = {24'h000000, state_q.extended_control};
            CRF_SEL_VBR: ctlRdData = state_q.vector_base;
            CRF_SEL_SBR: ctlRdData = state_q.short_address_base;
            CRF_SEL_MACH: ctlRdData = state_q.mac[63:32];
            CRF_SEL_MACL: ctlRdData = state_q.mac[31:0];
            default: ctlRdData = 32'h00000000;
        endcase
    end
    assign stackPointer = state_q.gpr[SP_INDEX];
    assign programCounter = state_q.pc;
    assign fetchAddr = {state_q.pc[31:1], 1'b0};
    assign aluResult = aluOut.res;
    assign conditionFlags = state_q.condition_flags;
    assign irqMasked = state_q.condition_flags[CCR_I];
    // user bit that may act as a second mask
    assign userMask = state_q.condition_flags[CCR_UI];
    // branch conditions N, Z, V, C
    assign branchFlags = state_q.condition_flags[CCR_N:CCR_C];

    // ==========================================================
    // Assertions
    // ==========================================================
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic arithNow; // Arithmetic flag update in this cycle, not overridden
    assign arithNow = aluReq.en && !(ctlReq.en && ctlReq.sel == CRF_SEL_CCR) &&
                      (aluReq.op inside {CRF_ALU_ADD, CRF_ALU_SUB, CRF_ALU_CMP});
    property p_fetchEven;
        fetchAddr[0] == 1'b0 && fetchAddr[31:1] == programCounter[31:1];
    endproperty
    a_fetchEven: assert property (p_fetchEven) else $error("fetch address odd");
    property p_excMask;
        excStart |=> irqMasked;
    endproperty
    a_excMask: assert property (p_excMask) else $error("mask not set on exception");
    property p_byteHalf;
        arithNow && aluReq.size == CRF_SZ_BYTE && aluReq.op == CRF_ALU_ADD |=>
            conditionFlags[CCR_H] == (($past(aluReq.a[3:0]) + $past(aluReq.b[3:0])) > 5'h0F);
    endproperty
    a_byteHalf: assert property (p_byteHalf) else $error("byte half-carry wrong");
    property p_wordHalf;
        arithNow && aluReq.size == CRF_SZ_WORD && aluReq.op == CRF_ALU_SUB |=>
            conditionFlags[CCR_H] == ($past(aluReq.a[11:0]) < $past(aluReq.b[11:0]));
    endproperty
    a_wordHalf: assert property (p_wordHalf) else $error("word half-borrow wrong");
    property p_longHalf;
        arithNow && aluReq.size == CRF_SZ_LONG && aluReq.op == CRF_ALU_ADD |=>
            conditionFlags[CCR_H] == (($past(aluReq.a[27:0]) + $past(aluReq.b[27:0])) > 29'h0FFFFFFF);
    endproperty
    a_longHalf: assert property (p_longHalf) else $error("long half-carry wrong");
    property p_zeroFlag;
        arithNow && aluReq.size == CRF_SZ_LONG |=> conditionFlags[CCR_Z] == ($past(aluOut.res) == 32'h0);
    endproperty
    a_zeroFlag: assert property (p_zeroFlag) else $error("zero flag wrong");
    property p_negFlag;
        arithNow && aluReq.size == CRF_SZ_WORD |=> conditionFlags[CCR_N] == $past(aluOut.res[15]);
    endproperty
    a_negFlag: assert property (p_negFlag) else $error("negative flag wrong");
    property p_byteKeep;
        gprWr.en && gprWr.view == CRF_VIEW_BYTEL && !spLoad |=>
            state_q.gpr[$past(gprWr.idx)][31:8] == $past(state_q.gpr[gprWr.idx][31:8]);
    endproperty
    a_byteKeep: assert property (p_byteKeep) else $error("byte write disturbed register");
    property p_spAlias;
        spLoad && !excStart |=> stackPointer == $past(spValue) ##0 rdAIdx != SP_INDEX ||
            rdAView != CRF_VIEW_LONG || rdAData == stackPointer;
    endproperty
    a_spAlias: assert property (p_spAlias) else $error("stack pointer not register seven");
    // A same-cycle datapath update changes the flags the XOR acts on, so it is left out here
    property p_ctlXor;
        ctlReq.en && ctlReq.sel == CRF_SEL_CCR && ctlReq.op == CRF_CTL_XOR && !excStart && !aluReq.en |=>
            conditionFlags == ($past(conditionFlags) ^ $past(ctlReq.data[7:0]));
    endproperty
    a_ctlXor: assert property (p_ctlXor) else $error("flags XOR wrong");
    c_exception: cover property (excStart ##1 irqMasked);
    c_byteCarry: cover property (arithNow && aluReq.size == CRF_SZ_BYTE ##1 conditionFlags[CCR_H]);
    c_partial: cover property (gprWr.en && gprWr.view == CRF_VIEW_BYTEH);
    c_ctlLoad: cover property (ctlReq.en && ctlReq.op == CRF_CTL_LOAD && ctlReq.sel == CRF_SEL_CCR);

endmodule

// ### verification/crf_exec_model.sv
// ==========================================
// Datapath stand-in driving the write side
// ==========================================
module crf_exec_model (
    input wire logic clk,
    output crf_pkg::crf_gpr_wr_t gprWr,
    output logic spLoad,
    output logic [31:0] spValue,
    output logic pcLoad,
    output logic [31:0] pcValue,
    output logic pcAdvance,
    output logic [3:0] pcStep,
    output crf_pkg::crf_alu_req_t aluReq,
    output crf_pkg::crf_ctl_req_t ctlReq,
    output logic excStart
);
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;

    // Everything idle from time zero
    initial begin
        gprWr = '0;
        spLoad = 1'b0;
        spValue = '0;
        pcLoad = 1'b0;
        pcValue = '0;
        pcAdvance = 1'b0;
        pcStep = 4'h2;
        aluReq = '0;
        ctlReq = '0;
        excStart = 1'b0;
    end

    // Strobes stand for exactly one rising edge, drop at the falling edge, then one idle cycle
    task automatic go();
        @(negedge clk);
        gprWr.en = 1'b0;
        spLoad = 1'b0;
        pcLoad = 1'b0;
        pcAdvance = 1'b0;
        aluReq.en = 1'b0;
        ctlReq.en = 1'b0;
        excStart = 1'b0;
        // Let an edge pass so the next call never raises a strobe in the step that dropped it
        @(negedge clk);
    endtask

    task automatic gpr(logic [2:0] i, crf_view_t v, logic [31:0] d);
        gprWr = '{1'b1, i, v, d};
        go();
    endtask

    task automatic load_stack(logic [31:0] d);
        spLoad = 1'b1;
        spValue = d;
        go();
    endtask

    task automatic load_counter(logic [31:0] d);
        pcLoad = 1'b1;
        pcValue = d;
        go();
    endtask

    task automatic advance(logic [3:0] s);
        pcAdvance = 1'b1;
        pcStep = s;
        go();
    endtask

    task automatic alu(crf_alu_op_t o, crf_size_t s, logic [31:0] a, logic [31:0] b, logic bi);
        aluReq = '{1'b1, o, s, a, b, bi};
        go();
    endtask

    task automatic ctl(crf_ctl_op_t o, crf_ctl_sel_t s, logic [31:0] d);
        ctlReq = '{1'b1, o, s, d};
        go();
    endtask

    // Exception entry pulse
    task automatic exc();
        excStart = 1'b1;
        go();
    endtask
endmodule

// ### verification/tb_cpu_register_file_and_flags.sv
// ==========================================
// Bench top
// ==========================================
module tb_cpu_register_file_and_flags;
    timeunit 1ns;
    timeprecision 1ns;
    import crf_pkg::*;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] rdAIdx = '0, rdBIdx = 3'h7, idxSel = '0;
    crf_view_t rdAView = CRF_VIEW_LONG, rdBView = CRF_VIEW_LONG;
    crf_size_t idxSize = CRF_SZ_LONG;
    crf_ctl_sel_t ctlRdSel = CRF_SEL_CCR;
    crf_gpr_wr_t gprWr;
    crf_alu_req_t aluReq;
    crf_ctl_req_t ctlReq;
    logic spLoad, pcLoad, pcAdvance, excStart, irqMasked, userMask;
    logic [3:0] pcStep, branchFlags;
    logic [7:0] conditionFlags;
    logic [31:0] spValue, pcValue, rdAData, rdBData, idxData, stackPointer;
    logic [31:0] programCounter, fetchAddr, aluResult, ctlRdData;
    int num_errors = 0;
    int n_checks = 0;
    // Arithmetic table: op, size, a, b, expected flags
    crf_alu_op_t tOp[6] = '{CRF_ALU_SUB, CRF_ALU_ADD, CRF_ALU_ADD, CRF_ALU_ADD, CRF_ALU_ADD, CRF_ALU_SUB};
    crf_size_t tSz[6] = '{CRF_SZ_WORD, CRF_SZ_BYTE, CRF_SZ_WORD, CRF_SZ_LONG, CRF_SZ_BYTE, CRF_SZ_BYTE};
    logic [31:0] tA[6] = '{32'h1000, 32'h0F, 32'h800, 32'h08000000, 32'h80, 32'h0};
    logic [31:0] tB[6] = '{32'h1, 32'h01, 32'h800, 32'h08000000, 32'h80, 32'h1};
    logic [7:0] tF[6] = '{8'hA0, 8'hA0, 8'hA0, 8'hA0, 8'h87, 8'hA9};

    always #10 clk = ~clk;

    crf_exec_model m (.clk(clk), .gprWr(gprWr), .spLoad(spLoad), .spValue(spValue), .pcLoad(pcLoad),
        .pcValue(pcValue), .pcAdvance(pcAdvance), .pcStep(pcStep), .aluReq(aluReq), .ctlReq(ctlReq),
        .excStart(excStart));

    crf_register_file dut (.clk(clk), .rst(rst), .rdAIdx(rdAIdx), .rdAView(rdAView), .rdAData(rdAData),
        .rdBIdx(rdBIdx), .rdBView(rdBView), .rdBData(rdBData), .idxSel(idxSel), .idxSize(idxSize),
        .idxData(idxData), .gprWr(gprWr), .spLoad(spLoad), .spValue(spValue), .stackPointer(stackPointer),
        .pcLoad(pcLoad), .pcValue(pcValue), .pcAdvance(pcAdvance), .pcStep(pcStep),
        .programCounter(programCounter), .fetchAddr(fetchAddr), .aluReq(aluReq), .aluResult(aluResult),
        .ctlReq(ctlReq), .ctlRdSel(ctlRdSel), .ctlRdData(ctlRdData), .excStart(excStart),
        .conditionFlags(conditionFlags), .irqMasked(irqMasked), .userMask(userMask),
        .branchFlags(branchFlags));

    // Compare helpers, one for 32-bit and one for 8-bit results
    task automatic chk32(string n, logic [31:0] e, logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", n, e, g);
        end
    endtask

    // Reads are combinational, so settle briefly off the edge, then realign to the falling edge
    task automatic look(logic [2:0] i, crf_view_t v, logic [31:0] e);
        rdAIdx = i;
        rdAView = v;
        #1;
        chk32("rdAData", e, rdAData);
        @(negedge clk);
    endtask

    task automatic close_out();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Watchdog: the sequence needs a few hundred cycles at most
    initial begin
        #100000;
        num_errors++;
        close_out();
    end

    initial begin
        repeat (20) @(negedge clk);
        rst = 1'b0;
        chk8("flags", 8'h80, conditionFlags);
        chk8("irqMasked", 8'h01, {7'h0, irqMasked});
        for (int i = 0; i < 8; i++) m.gpr(i[2:0], CRF_VIEW_LONG, {8{i[3:0]}});
        for (int i = 0; i < 8; i++) look(i[2:0], CRF_VIEW_LONG, {8{i[3:0]}});
        chk32("stackPointer", 32'h77777777, stackPointer);
        // Successive partial writes must merge into one register
        m.gpr(3'h2, CRF_VIEW_BYTEL, 32'hAB);
        m.gpr(3'h2, CRF_VIEW_BYTEH, 32'hCD);
        m.gpr(3'h2, CRF_VIEW_EXT, 32'hBEEF);
        look(3'h2, CRF_VIEW_LONG, 32'hBEEFCDAB);
        look(3'h2, CRF_VIEW_EXT, 32'hBEEF);
        look(3'h2, CRF_VIEW_WORD, 32'hCDAB);
        look(3'h2, CRF_VIEW_BYTEH, 32'hCD);
        idxSel = 3'h2;
        idxSize = CRF_SZ_BYTE;
        #1;
        chk32("idxData", 32'hAB, idxData);
        @(negedge clk);
        m.load_stack(32'h0000FFF0);
        chk32("stackPointer", 32'h0000FFF0, stackPointer);
        chk32("rdBData", 32'h0000FFF0, rdBData);
        m.load_counter(32'h00001001);
        chk32("programCounter", 32'h00001001, programCounter);
        chk32("fetchAddr", 32'h00001000, fetchAddr);
        m.advance(4'h2);
        chk32("fetchAddr", 32'h00001002, fetchAddr);
        // Half-carry at each size, then zero, overflow, carry, negative
        for (int k = 0; k < 6; k++) begin
            m.alu(tOp[k], tSz[k], tA[k], tB[k], 1'b0);
            chk8("flags", tF[k], conditionFlags);
        end
        chk8("branchFlags", 8'h09, {4'h0, branchFlags});
        // Byte 0 minus 1 leaves the sized result all ones, zero-extended
        chk32("aluResult", 32'h000000FF, aluResult);
        m.alu(CRF_ALU_BITACC, CRF_SZ_BYTE, 32'h0, 32'h0, 1'b0);
        chk8("flags", 8'hA8, conditionFlags);
        m.ctl(CRF_CTL_LOAD, CRF_SEL_CCR, 32'h50);
        chk8("userMask", 8'h01, {7'h0, userMask});
        chk8("irqMasked", 8'h00, {7'h0, irqMasked});
        m.ctl(CRF_CTL_OR, CRF_SEL_CCR, 32'h01);
        chk8("flags", 8'h51, conditionFlags);
        m.ctl(CRF_CTL_AND, CRF_SEL_CCR, 32'hFE);
        m.ctl(CRF_CTL_XOR, CRF_SEL_CCR, 32'h10);
        chk8("flags", 8'h40, ctlRdData[7:0]);
        m.exc();
        chk8("flags", 8'hC0, conditionFlags);
        m.ctl(CRF_CTL_LOAD, CRF_SEL_EXR, 32'h0);
        ctlRdSel = CRF_SEL_EXR;
        #1;
        chk8("extended_control", 8'h78, ctlRdData[7:0]);
        @(negedge clk);
        m.ctl(CRF_CTL_LOAD, CRF_SEL_VBR, 32'hFFFFFFFF);
        ctlRdSel = CRF_SEL_VBR;
        #1;
        chk32("vector_base", 32'hFFFFF000, ctlRdData);
        close_out();
    end
endmodule
